// file: ptp_addend_target_time.sv
module ptp_addend_target_time (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [31:0] sys_sec_in,
  input  wire logic [30:0] sys_nsec_in,
  output logic             time_advance_out,
  output logic             fine_update_select_out,
  output logic             digital_rollover_select_out,
  output logic             target_event_out,
  output logic             irq_out
);
  import ptp_tt_pkg::*;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // true when the address hits a mapped register
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == ADDEND_OFF) || (a == TSEC_OFF) || (a == TNSEC_OFF) ||
           (a == STATUS_OFF) || (a == CTRL_OFF) || (a == IRQ_STAT_OFF) ||
           (a == IRQ_MASK_OFF);
  endfunction : is_mapped

  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [11:0] awaddr_r, awaddr_nxt, araddr_q;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] addend_r, addend_nxt, tsec_r, tsec_nxt;
  logic [30:0] tnsec_r, tnsec_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [31:0] irq_mask_r, irq_mask_nxt, irq_stat_r, irq_stat_nxt;
  logic        reached_r, reached_nxt, err_r, err_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic        adv_r, adv_nxt;
  logic        armed_r, armed_nxt, check_r, check_nxt;
  logic        event_r, event_nxt;
  logic        wr_fire, rd_fire, rd_clr, hit, evt, err_evt, fine;
  logic [32:0] sum;
  logic [31:0] wr_word, rd_word;

  // bus handshakes: address and data are taken in either order
  assign wr_fire           = aw_have_r && w_have_r && !bvalid_r;
  assign rd_fire           = s_axi_arvalid_in && !rvalid_r;
  assign s_axi_awready_out = !aw_have_r;
  assign s_axi_wready_out  = !w_have_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_bvalid_out  = bvalid_r;
  assign s_axi_bresp_out   = bresp_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rresp_out   = rresp_r;
  assign s_axi_rdata_out   = rdata_r;
  assign araddr_q          = s_axi_araddr_in;
  assign rd_clr            = rd_fire && (araddr_q == STATUS_OFF);
  assign fine              = ctrl_r[CTRL_FINE_BIT];
  assign fine_update_select_out      = ctrl_r[CTRL_FINE_BIT];
  // sub-second rollover mode for the external time counter comes from the control register
  assign digital_rollover_select_out = ctrl_r[CTRL_DIG_BIT];
  assign time_advance_out  = adv_r;
  assign target_event_out  = event_r;
  // level output, high while any unmasked sticky bit stands
  assign irq_out           = |(irq_stat_r & irq_mask_r);

  // read mux; the target ns top bit is reserved and reads zero
  always_comb begin
    rd_word = ZERO32;
    case (araddr_q)
      ADDEND_OFF:   rd_word = addend_r;
      TSEC_OFF:     rd_word = tsec_r;
      TNSEC_OFF:    rd_word = {1'b0, tnsec_r};
      STATUS_OFF: begin
        rd_word[ST_REACHED_BIT] = reached_r;
        rd_word[ST_ERROR_BIT]   = err_r;
      end
      CTRL_OFF:     rd_word = {30'h0000_0000, ctrl_r};
      IRQ_STAT_OFF: rd_word = irq_stat_r;
      IRQ_MASK_OFF: rd_word = irq_mask_r;
      default:      rd_word = ZERO32;
    endcase
  end

  // bus channel and register next state
  always_comb begin
    aw_have_nxt  = aw_have_r;
    awaddr_nxt   = awaddr_r;
    w_have_nxt   = w_have_r;
    wdata_nxt    = wdata_r;
    wstrb_nxt    = wstrb_r;
    bvalid_nxt   = bvalid_r;
    bresp_nxt    = bresp_r;
    rvalid_nxt   = rvalid_r;
    rresp_nxt    = rresp_r;
    rdata_nxt    = rdata_r;
    addend_nxt   = addend_r;
    tsec_nxt     = tsec_r;
    tnsec_nxt    = tnsec_r;
    ctrl_nxt     = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    wr_word      = ZERO32;
    if (s_axi_awvalid_in && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_have_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata_in;
      wstrb_nxt  = s_axi_wstrb_in;
    end
    if (wr_fire) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      case (awaddr_r)
        ADDEND_OFF: addend_nxt = merge_bytes(addend_r, wdata_r, wstrb_r);
        TSEC_OFF:   tsec_nxt   = merge_bytes(tsec_r, wdata_r, wstrb_r);
        TNSEC_OFF: begin
          wr_word   = merge_bytes({1'b0, tnsec_r}, wdata_r, wstrb_r);
          tnsec_nxt = wr_word[NSEC_W-1:0];
        end
        CTRL_OFF: begin
          wr_word  = merge_bytes({30'h0000_0000, ctrl_r}, wdata_r, wstrb_r);
          ctrl_nxt = wr_word[1:0];
        end
        IRQ_MASK_OFF: begin
          wr_word      = merge_bytes(irq_mask_r, wdata_r, wstrb_r);
          irq_mask_nxt = wr_word & IRQ_USED;
        end
        default: wr_word = ZERO32;
      endcase
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = is_mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
  end

  // bus and software register state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_r  <= 1'b0;
      awaddr_r   <= 12'h000;
      w_have_r   <= 1'b0;
      wdata_r    <= ZERO32;
      wstrb_r    <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= ZERO32;
      addend_r   <= ADDEND_RST;
      tsec_r     <= TSEC_RST;
      tnsec_r    <= TNSEC_RST;
      ctrl_r     <= 2'h0;
      irq_mask_r <= ZERO32;
    end else begin
      aw_have_r  <= aw_have_nxt;
      awaddr_r   <= awaddr_nxt;
      w_have_r   <= w_have_nxt;
      wdata_r    <= wdata_nxt;
      wstrb_r    <= wstrb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
      addend_r   <= addend_nxt;
      tsec_r     <= tsec_nxt;
      tnsec_r    <= tnsec_nxt;
      ctrl_r     <= ctrl_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // addend accumulator; coarse mode steps time every cycle instead
  assign sum = {1'b0, acc_r} + {1'b0, addend_r};
  always_comb begin
    acc_nxt = acc_r;
    adv_nxt = 1'b1;                   // coarse: addend is ignored
    if (fine) begin
      acc_nxt = sum[31:0];            // wrapped remainder is kept
      adv_nxt = sum[32];              // step only on carry out
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r <= ZERO32;
      adv_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      adv_r <= adv_nxt;
    end
  end

  // target compare runs every cycle; seconds rank above nanoseconds
  assign hit = (sys_sec_in > tsec_r) ||
               ((sys_sec_in == tsec_r) && (sys_nsec_in >= tnsec_r));

  // a target write disarms, then one cycle later either arms or flags
  // a late target; each half of the pair is checked and armed on its own, and a target already passed raises the error flag, not the event
  always_comb begin
    check_nxt = wr_fire && ((awaddr_r == TSEC_OFF) ||
                            (awaddr_r == TNSEC_OFF));
    armed_nxt = armed_r;
    evt       = 1'b0;
    err_evt   = 1'b0;
    if (check_r) begin
      armed_nxt = !hit;
      err_evt   = hit;
    end else if (armed_r && hit) begin
      armed_nxt = 1'b0;                            // once per crossing
      evt       = 1'b1;
    end
    if (check_nxt) begin
      armed_nxt = 1'b0;
    end
    event_nxt   = evt;
    // a set in the same cycle as the read-clear wins
    reached_nxt = evt || (reached_r && !rd_clr);
    err_nxt     = err_evt || (err_r && !rd_clr);
    irq_stat_nxt = irq_stat_r;
    if (wr_fire && (awaddr_r == IRQ_STAT_OFF)) begin
      irq_stat_nxt = irq_stat_r & ~(wdata_r & IRQ_USED);
    end
    irq_stat_nxt[IRQ_TS_BIT]  = irq_stat_nxt[IRQ_TS_BIT] | evt;
    irq_stat_nxt[IRQ_ERR_BIT] = irq_stat_nxt[IRQ_ERR_BIT] | err_evt;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      check_r    <= 1'b0;
      armed_r    <= 1'b0;
      event_r    <= 1'b0;
      reached_r  <= 1'b0;
      err_r      <= 1'b0;
      irq_stat_r <= ZERO32;
    end else begin
      check_r    <= check_nxt;
      armed_r    <= armed_nxt;
      event_r    <= event_nxt;
      reached_r  <= reached_nxt;
      err_r      <= err_nxt;
      irq_stat_r <= irq_stat_nxt;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_target_write;
    wr_fire && (awaddr_r == TNSEC_OFF || awaddr_r == TSEC_OFF);
  endsequence
  sequence s_late_check;
    check_r && hit;
  endsequence

  a_fine_accumulate: assert property (
    fine |=> acc_r == 32'($past(acc_r) + $past(addend_r)))
    else $error("accumulator did not add the addend");
  a_coarse_hold: assert property (
    // the release edge still clocks the reset value into the strobe
    rst_n_in && !fine |=> (acc_r == $past(acc_r)) && adv_r)
    else $error("coarse mode touched the accumulator");
  a_carry_advance: assert property (
    fine |=> adv_r == ($past(acc_r) > (32'hFFFF_FFFF - $past(addend_r))))
    else $error("time advance does not follow the carry");
  a_late_error: assert property (
    s_target_write ##1 s_late_check |=> err_r && !event_r)
    else $error("late target not flagged as error");
  a_event_cause: assert property (
    event_r |-> $past(hit) && $past(armed_r) && !$past(check_r))
    else $error("target event without a crossing");
  a_event_once: assert property (
    event_r |=> !event_r [*2])
    else $error("target event repeated");
  a_reached_set: assert property (
    event_r |-> reached_r && irq_stat_r[IRQ_TS_BIT])
    else $error("reached flag or irq status not set");
  a_irq_gated: assert property (
    (irq_stat_r[IRQ_TS_BIT] && !irq_mask_r[IRQ_TS_BIT] &&
     !irq_stat_r[IRQ_ERR_BIT]) |-> !irq_out)
    else $error("masked target event raised the interrupt");
  a_read_clear: assert property (
    (rd_clr && !evt && !err_evt) |=> !reached_r && !err_r)
    else $error("status read did not clear the flags");

endmodule : ptp_addend_target_time

// file: ptp_tt_pkg.sv
package ptp_tt_pkg;
  // register byte offsets on the 12-bit slave address
  localparam logic [11:0] ADDEND_OFF   = 12'h718;
  localparam logic [11:0] TSEC_OFF     = 12'h71C;
  localparam logic [11:0] TNSEC_OFF    = 12'h720;
  localparam logic [11:0] STATUS_OFF   = 12'h728;
  localparam logic [11:0] CTRL_OFF     = 12'h740;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h744;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h748;

  // field positions
  localparam int ST_REACHED_BIT = 1;
  localparam int ST_ERROR_BIT   = 3;
  localparam int CTRL_FINE_BIT  = 0;
  localparam int CTRL_DIG_BIT   = 1;
  localparam int IRQ_ERR_BIT    = 3;
  localparam int IRQ_TS_BIT     = 9;

  // widths and reset values
  localparam int          NSEC_W     = 31;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [30:0] ZERO31     = 31'h0000_0000;
  localparam logic [31:0] ADDEND_RST = 32'h0000_0000;
  localparam logic [31:0] TSEC_RST   = 32'h0000_0000;
  localparam logic [30:0] TNSEC_RST  = 31'h0000_0000;
  localparam logic [31:0] IRQ_USED   = 32'h0000_0208;
  // largest legal sub-second value with digital rollover
  localparam logic [30:0] NSEC_MAX   = 31'h3B9A_C9FF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ptp_tt_pkg

// file: test_ptp_addend_target_time.sv
module test_ptp_addend_target_time;
  timeunit 1ns;
  timeprecision 1ps;
  import ptp_tt_pkg::*;

  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [11:0] awaddr   = 12'h000;
  logic [11:0] araddr   = 12'h000;
  logic [31:0] wdata    = 32'h0000_0000;
  logic [3:0]  wstrb    = 4'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic [31:0] sys_sec  = 32'h0000_0005;
  logic [30:0] sys_nsec = 31'h0000_0064;
  logic [1:0]  resp;
  wire  logic  awready, wready, bvalid, arready, rvalid;
  wire  logic  adv, fine_sel, dig_sel, tevt, irq;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          checks     = 0;
  int          n_mismatch = 0;

  ptp_addend_target_time i_ptp_addend_target_time (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sys_sec_in(sys_sec),
    .sys_nsec_in(sys_nsec), .time_advance_out(adv),
    .fine_update_select_out(fine_sel),
    .digital_rollover_select_out(dig_sel),
    .target_event_out(tevt), .irq_out(irq));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // one aligned word; address and data offered together, taken in any order
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    @(posedge clk_in);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // the leading edge keeps ready strobes from being assigned twice per step
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // pulses seen over eight edges, advance strobe or target event
  task automatic cnt(input logic sel, output int c);
    c = 0;
    repeat (8) begin
      @(posedge clk_in);
      if ((sel ? tevt : adv) === 1'b1) c++;
    end
  endtask : cnt

  // settle two cycles so the accumulator runs on the new addend only
  task automatic pace(input logic [31:0] ad, output int c);
    wr(ADDEND_OFF, ad);
    repeat (2) @(posedge clk_in);
    cnt(1'b0, c);
  endtask : pace

  task automatic t_regs();
    logic [31:0] v;
    int          c;
    // the first edge after release still shows the strobe's reset value
    @(posedge clk_in);
    cnt(1'b0, c);
    chk32(32'(c), 32'h8);
    rd(ADDEND_OFF, v);
    chk32(v, ADDEND_RST);
    rd(TSEC_OFF, v);
    chk32(v, TSEC_RST);
    rd(TNSEC_OFF, v);
    chk32(v, {1'b0, TNSEC_RST});
    wr(ADDEND_OFF, 32'hA5A5_5A5A);
    chk32({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(ADDEND_OFF, v);
    chk32(v, 32'hA5A5_5A5A);
    wr(TSEC_OFF, 32'hFFFF_FFFF);
    rd(TSEC_OFF, v);
    chk32(v, 32'hFFFF_FFFF);
    wr(TNSEC_OFF, 32'hFFFF_FFFF);
    rd(TNSEC_OFF, v);
    chk32(v, 32'h7FFF_FFFF);
    wr(12'h7FC, 32'hFFFF_FFFF);
    chk32({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(12'h7FC, v);
    chk32({v[31:2], resp}, {30'h0, RESP_SLVERR});
  endtask : t_regs

  task automatic t_accum();
    int c;
    wr(CTRL_OFF, 32'h0000_0003);
    chk1(fine_sel, 1'b1);
    chk1(dig_sel, 1'b1);
    pace(ZERO32, c);
    chk32(32'(c), 32'h0);
    pace(32'h8000_0000, c);
    chk32(32'(c), 32'h4);
    // 3/8 of a wrap per cycle: exact only if the remainder is kept
    pace(32'h6000_0000, c);
    chk32(32'(c), 32'h3);
    // coarse mode; digital rollover stays on for the target scenarios
    wr(CTRL_OFF, 32'h0000_0002);
    pace(32'h6000_0000, c);
    chk32(32'(c), 32'h8);
  endtask : t_accum

  task automatic t_target();
    logic [31:0] v;
    int          c;
    wr(IRQ_MASK_OFF, IRQ_USED);
    wr(TSEC_OFF, 32'h0000_0006);
    wr(TNSEC_OFF, 32'h0000_00C8);
    rd(STATUS_OFF, v);
    wr(IRQ_STAT_OFF, IRQ_USED);
    @(posedge clk_in);
    sys_sec <= 32'h0000_0006;
    sys_nsec <= 31'h0000_00C7;
    cnt(1'b1, c);
    chk32(32'(c), 32'h0);
    chk1(irq, 1'b0);
    sys_nsec <= 31'h0000_00C8;
    cnt(1'b1, c);
    chk32(32'(c), 32'h1);
    chk1(irq, 1'b1);
    rd(STATUS_OFF, v);
    chk32(v, 32'h0000_0002);
    rd(STATUS_OFF, v);
    chk32(v, ZERO32);
    rd(IRQ_STAT_OFF, v);
    chk32(v, 32'h0000_0200);
    // masking the pending target bit must drop the level output
    wr(IRQ_MASK_OFF, 32'h0000_0008);
    chk1(irq, 1'b0);
    wr(IRQ_MASK_OFF, IRQ_USED);
    chk1(irq, 1'b1);
    wr(IRQ_STAT_OFF, 32'h0000_0200);
    @(posedge clk_in);
    chk1(irq, 1'b0);
  endtask : t_target

  task automatic t_error();
    logic [31:0] v;
    wr(IRQ_MASK_OFF, ZERO32);
    // a target of one second is already behind the running time
    wr(TSEC_OFF, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    chk1(irq, 1'b0);
    rd(IRQ_STAT_OFF, v);
    chk32(v, 32'h0000_0008);
    rd(STATUS_OFF, v);
    chk32(v, 32'h0000_0008);
    rd(STATUS_OFF, v);
    chk32(v, ZERO32);
    wr(IRQ_MASK_OFF, 32'h0000_0008);
    @(posedge clk_in);
    chk1(irq, 1'b1);
    wr(IRQ_STAT_OFF, 32'h0000_0008);
    @(posedge clk_in);
    chk1(irq, 1'b0);
  endtask : t_error

  task automatic stop_test();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // reset for six cycles, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_accum();
    t_target();
    t_error();
    stop_test();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule : test_ptp_addend_target_time
